// ==== srs_sequencer.sv ====
// Staged system reset sequencer: merges sources and releases resets in order.
// Assumes clock is the oscillator clock and system_clock_tick is a one-cycle
// enable marking each system clock cycle, made by the clock generator.
module srs_sequencer import srs_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Asynchronous sources
    input wire logic power_on_reset,
    input wire logic reset_pin_n,
    // Synchronous sources and clock enables
    input wire srs_sync_src_t sync_src,
    input wire logic system_clock_tick,
    input wire logic x3_request,
    // Staged resets
    output logic extended_por_r,
    output logic clock_gen_reset_r,
    output logic peripheral_reset_r,
    output logic core_reset_r,
    output logic test_port_reset_r,
    // Clock distribution
    output logic fast_clock_enable_r
);

    logic [SYNC_STAGES-1:0] por_sync_r;
    logic [SYNC_STAGES-1:0] pin_sync_r;
    logic ext_por_done;
    logic clock_gen_done;
    logic peripheral_done;
    logic core_done;

    // Either asynchronous source presets the clock-gen, peripheral and core resets at once; this OR is a
    // reset net only, so a short glitch can only lengthen reset.
    wire logic pin_active = !reset_pin_n;
    wire logic async_any = power_on_reset | pin_active;

    // Release is brought onto the clock through two flops.
    always_ff @(posedge clock or posedge power_on_reset) begin
        if (power_on_reset) begin
            por_sync_r <= SYNC_PRESET;
        end else begin
            por_sync_r <= {por_sync_r[0], 1'b0};
        end
    end

    always_ff @(posedge clock or posedge pin_active) begin
        if (pin_active) begin
            pin_sync_r <= SYNC_PRESET;
        end else begin
            pin_sync_r <= {pin_sync_r[0], 1'b0};
        end
    end

    wire logic por_hold = por_sync_r[SYNC_STAGES-1];
    wire logic pin_hold = pin_sync_r[SYNC_STAGES-1];
    wire logic sync_any = |sync_src;
    // Any source in any stage holds every later counter at zero.
    wire logic src_active = por_hold | !ext_por_done | pin_hold | sync_any;
    wire logic clock_gen_hold = src_active | !clock_gen_done;
    wire logic peripheral_hold = clock_gen_hold | !peripheral_done;

    // Early stages count every oscillator cycle.
    srs_delay #(.COUNT(POR_STRETCH_CYCLES)) u_por_delay (
        .clock(clock),
        .srst(srst),
        .hold(por_hold),
        .tick(1'b1),
        .done_r(ext_por_done)
    );

    srs_delay #(.COUNT(CLOCK_GEN_CYCLES)) u_clock_gen_delay (
        .clock(clock),
        .srst(srst),
        .hold(src_active),
        .tick(1'b1),
        .done_r(clock_gen_done)
    );

    // Peripheral and core stages share one system clock tick.
    srs_delay #(.COUNT(PERIPHERAL_CYCLES)) u_peripheral_delay (
        .clock(clock),
        .srst(srst),
        .hold(clock_gen_hold),
        .tick(system_clock_tick),
        .done_r(peripheral_done)
    );

    srs_delay #(.COUNT(CORE_CYCLES)) u_core_delay (
        .clock(clock),
        .srst(srst),
        .hold(peripheral_hold),
        .tick(system_clock_tick),
        .done_r(core_done)
    );

    wire logic extended_por_nxt = por_hold | !ext_por_done;
    wire logic clock_gen_reset_nxt = clock_gen_hold;
    wire logic peripheral_reset_nxt = peripheral_hold;
    wire logic core_reset_nxt = peripheral_hold | !core_done;
    // Only power-on reset reaches the test port.
    wire logic test_port_reset_nxt = por_hold;
    // Fast timer and PWM clocks stay off while peripherals are in reset.
    wire logic fast_clock_enable_nxt = x3_request & !peripheral_hold;

    always_ff @(posedge clock or posedge power_on_reset) begin
        if (power_on_reset) begin
            extended_por_r <= 1'b1;
            test_port_reset_r <= 1'b1;
        end else if (srst) begin
            extended_por_r <= 1'b1;
            test_port_reset_r <= 1'b1;
        end else begin
            extended_por_r <= extended_por_nxt;
            test_port_reset_r <= test_port_reset_nxt;
        end
    end

    always_ff @(posedge clock or posedge async_any) begin
        if (async_any) begin
            clock_gen_reset_r <= 1'b1;
            peripheral_reset_r <= 1'b1;
            core_reset_r <= 1'b1;
            fast_clock_enable_r <= 1'b0;
        end else if (srst) begin
            clock_gen_reset_r <= 1'b1;
            peripheral_reset_r <= 1'b1;
            core_reset_r <= 1'b1;
            fast_clock_enable_r <= 1'b0;
        end else begin
            clock_gen_reset_r <= clock_gen_reset_nxt;
            peripheral_reset_r <= peripheral_reset_nxt;
            core_reset_r <= core_reset_nxt;
            fast_clock_enable_r <= fast_clock_enable_nxt;
        end
    end

    // Helper counters of quiet cycles, read only by the checks below.
    logic [7:0] por_quiet_r;
    logic [7:0] src_quiet_r;
    always_ff @(posedge clock) begin
        if (srst || por_hold) begin
            por_quiet_r <= 8'h00;
        end else if (por_quiet_r != 8'hFF) begin
            por_quiet_r <= por_quiet_r + 8'h01;
        end
        if (srst || src_active) begin
            src_quiet_r <= 8'h00;
        end else if (src_quiet_r != 8'hFF) begin
            src_quiet_r <= src_quiet_r + 8'h01;
        end
    end

    a_por_stretch_len: assert property (
        @(posedge clock) disable iff (srst)
        $fell(extended_por_r) |-> por_quiet_r == 8'(POR_STRETCH_CYCLES + 1)
    ) else $error("extended power-on reset released at wrong time");

    a_clock_gen_len: assert property (
        @(posedge clock) disable iff (srst)
        $fell(clock_gen_reset_r) |-> src_quiet_r == 8'(CLOCK_GEN_CYCLES + 1)
    ) else $error("clock generator reset released at wrong time");

    a_peripheral_after: assert property (
        @(posedge clock) disable iff (srst)
        $fell(peripheral_reset_r) |->
            !clock_gen_reset_r && !$past(clock_gen_reset_r)
    ) else $error("peripheral reset released before clock generator reset");

    a_core_last_out: assert property (
        @(posedge clock) disable iff (srst)
        !core_reset_r |-> !peripheral_reset_r && !clock_gen_reset_r
    ) else $error("core reset clear while an earlier stage is held");

    a_pin_asserts_all: assert property (
        @(posedge clock) disable iff (srst)
        !reset_pin_n |->
            clock_gen_reset_r && peripheral_reset_r && core_reset_r
    ) else $error("reset pin did not hold all stages");

    a_sync_src_restart: assert property (
        @(posedge clock) disable iff (srst)
        sync_any |=> clock_gen_reset_r && peripheral_reset_r && core_reset_r
    ) else $error("synchronous source did not reassert all stages");

    a_sw_reset_hold: assert property (
        @(posedge clock) disable iff (srst)
        sync_src.sw_write |=> core_reset_r [*8]
    ) else $error("software reset did not hold the core");

    a_test_port_por: assert property (
        @(posedge clock) disable iff (srst)
        $rose(test_port_reset_r) |-> power_on_reset || $past(power_on_reset)
    ) else $error("test port reset set by a source other than power-on");

    a_release_synced: assert property (
        @(posedge clock) disable iff (srst)
        $fell(clock_gen_reset_r) |->
            $past(reset_pin_n, 2) && $past(reset_pin_n, 3)
    ) else $error("clock generator released without synchronised pin");

    // A pin release must pass both flops before the counters see it.
    a_pin_two_flops: assert property (
        @(posedge clock) disable iff (srst)
        !pin_hold |-> $past(reset_pin_n) && $past(reset_pin_n, 2)
    ) else $error("pin release reached the counters too early");

    a_restart_counters: assert property (
        @(posedge clock) disable iff (srst)
        sync_any |=> !clock_gen_done && !peripheral_done && !core_done
    ) else $error("synchronous source did not restart the counters");

    a_fast_clock_req: assert property (
        @(posedge clock) disable iff (srst)
        fast_clock_enable_r |-> $past(x3_request) && !peripheral_reset_r
    ) else $error("fast clock enabled without request");

    a_clock_rate_max: assert property (
        @(posedge clock) CLOCK_HZ <= SYS_MAX_HZ
    ) else $error("clock rate above system maximum");

    c_full_release: cover property (
        @(posedge clock) disable iff (srst) $fell(core_reset_r));
    c_restart_midway: cover property (
        @(posedge clock) disable iff (srst)
        !clock_gen_reset_r && peripheral_reset_r && sync_any);
    c_fast_clock_on: cover property (
        @(posedge clock) disable iff (srst) $rose(fast_clock_enable_r));
    c_por_again: cover property (
        @(posedge clock) disable iff (srst) $rose(test_port_reset_r));

endmodule // srs_sequencer

// ==== srs_pkg.sv ====
// Constants and carrier types for the staged system reset sequencer.
// Assumes one clock, the oscillator clock, with the system clock as an enable.
// Function
// - Reset pin and power-on reset assert resets with no clock running.
// - Software and both watchdog resets are synchronous sources.
// - A system control register write produces the software reset.
// - Extended power-on reset ends 64 oscillator cycles after power-on.
// - Clock-gen reset ends 32 oscillator cycles after all sources end.
// - Peripheral reset ends 32 system clocks after clock-gen reset ends.
// - Core reset ends last, 32 system clocks after peripheral reset ends.
// - Test-port reset follows power-on reset only.
// - Power-on and clock-generator delays count oscillator clock cycles.
// - Memory, peripheral and core clocks share one rate, at most 32 MHz.
// - Both quad timers and the PWM may run at three times system clock.
package srs_pkg;

    localparam int CLOCK_HZ = 25_000_000;
    localparam int SYS_MAX_HZ = 32_000_000;
    localparam int POR_STRETCH_CYCLES = 64;
    localparam int CLOCK_GEN_CYCLES = 32;
    localparam int PERIPHERAL_CYCLES = 32;
    localparam int CORE_CYCLES = 32;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] SYNC_PRESET = 2'h3;

    // Synchronous reset requests, all on the oscillator clock.
    typedef struct packed {
        logic sw_write;
        logic watchdog_timeout_reset;
        logic watchdog_lost_reference_reset;
    } srs_sync_src_t;

endpackage

// ==== srs_delay.sv ====
// Release delay counter for one reset stage.
// Assumes hold and tick come from logic on the same clock.
module srs_delay import srs_pkg::*; #(
    parameter int COUNT = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Control
    input wire logic hold,
    input wire logic tick,
    // Status
    output logic done_r
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] cnt_r;
    wire logic at_last = (cnt_r == LAST);

    // A hold at any point clears the count, so the stage restarts in full.
    always_ff @(posedge clock) begin
        if (srst || hold) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (tick && !done_r) begin
            cnt_r <= cnt_r + CW'(1);
            done_r <= at_last;
        end
    end

endmodule // srs_delay

// ==== srs_clkgen_model.sv ====
// Clock generator model that paces the system clock as an enable.
// Assumes the bench picks full or one-third rate between sequences.
module srs_clkgen_model (
    // Clock
    input wire logic clock,
    // Control
    input wire logic slow,
    // System clock enable
    output logic tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_r = 2'h0;
    always_ff @(posedge clock) begin
        div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    end
    // A slow system clock shows stage counts that wrongly use the oscillator.
    assign tick = !slow || div_r == 2'h0;
endmodule // srs_clkgen_model

// ==== testbench.sv ====
// Self-checking bench for the staged reset sequencer.
// Assumes a 25 MHz oscillator clock and drives inputs on falling edges.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import srs_pkg::*;
    logic clock = 1'b0, srst = 1'b1, por = 1'b1, pin_n = 1'b1;
    logic x3 = 1'b0, slow = 1'b0, tick, ext, cg, per, core, tp, fast;
    srs_sync_src_t src = '0;
    int mismatches = 0, total_checks = 0, cycles = 0;
    int t [4];
    wire logic [4:0] rs = {tp, core, per, cg, ext};
    srs_clkgen_model model (.clock(clock), .slow(slow), .tick(tick));
    srs_sequencer dut (.clock(clock), .srst(srst), .power_on_reset(por),
        .reset_pin_n(pin_n), .sync_src(src), .system_clock_tick(tick),
        .x3_request(x3), .extended_por_r(ext), .clock_gen_reset_r(cg),
        .peripheral_reset_r(per), .core_reset_r(core),
        .test_port_reset_r(tp), .fast_clock_enable_r(fast));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // The whole run needs about 4300 cycles, so this ceiling means a hang.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[FAIL] %0t got %0h exp %0h..%0h", $time, got, lo, hi);
        end
    endtask
    // Records the cycle at which each stage but the test port first reads low.
    task automatic measure();
        t = '{-1, -1, -1, -1};
        for (int n = 0; n < 600; n++) begin
            @(negedge clock);
            for (int k = 0; k < 4; k++) begin
                if (rs[k] !== 1'b1 && t[k] < 0) t[k] = n;
            end
        end
    endtask
    task automatic t_por();
        @(negedge clock) por = 1'b1;
        #1 chk(rs, 5'h1F);
        @(negedge clock) por = 1'b0;
        measure();
        rng(t[0], 64, 70);
        rng(t[1] - t[0], 32, 35);
        rng(t[2] - t[1], 31, 34);
        rng(t[3] - t[2], 31, 34);
        chk(rs, 5'h00);
    endtask
    task automatic t_fast();
        x3 = 1'b1;
        repeat (2) @(negedge clock);
        chk({4'h0, fast}, 5'h01);
        pin_n = 1'b0;
        #1 chk(rs, 5'h0E);
        repeat (2) @(negedge clock);
        chk({4'h0, fast}, 5'h00);
        slow = 1'b1;
        pin_n = 1'b1;
        measure();
        rng(t[1], 33, 37);
        rng(t[2] - t[1], 93, 99);
        rng(t[3] - t[2], 93, 99);
        slow = 1'b0;
    endtask
    task automatic t_sync();
        for (int i = 0; i < 3; i++) begin
            src = srs_sync_src_t'(3'h1 << i);
            @(negedge clock) src = '0;
            chk(rs, 5'h0E);
            measure();
            rng(t[1], 31, 36);
            rng(t[3] - t[2], 31, 34);
        end
    endtask
    task automatic t_restart();
        pin_n = 1'b0;
        @(negedge clock) pin_n = 1'b1;
        repeat (45) @(negedge clock);
        chk(rs, 5'h0C);
        src.watchdog_timeout_reset = 1'b1;
        @(negedge clock) src = '0;
        chk(rs, 5'h0E);
        measure();
        rng(t[1], 31, 36);
        rng(t[2] - t[1], 31, 34);
    endtask
    initial begin
        repeat (10) @(negedge clock);
        srst = 1'b0;
        t_por();
        t_fast();
        t_sync();
        t_restart();
        // A second power-on in mid-run must preset every stage at once.
        t_por();
        summarize();
    end
endmodule // testbench
